// ===== bench/ffau_issuer.sv
// issue-side model: presents one request, holds it until taken, awaits the answer
`timescale 1ns/1ns
`default_nettype none
module ffau_issuer
  import ffau_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_ready,
  input wire ffau_pkg::ffau_rsp_t i_rsp,
  output var ffau_pkg::ffau_req_t o_req
);
  initial begin
    o_req = '0;
  end

  task automatic issue(input ffau_op_t op, input logic dbl, input logic rnd,
                       input logic [59:0] a, input logic [59:0] b,
                       output ffau_rsp_t rsp, output int lat);
    lat = 0;
    @(posedge i_clk);
    o_req <= '{valid: 1'b1, op: op, dbl: dbl, rnd: rnd, a: a, b: b};
    do @(posedge i_clk); while (i_ready !== 1'b1);
    // released operands no longer show the old value
    o_req <= '{valid: 1'b0, op: op, dbl: dbl, rnd: rnd, a: ~a, b: ~b};
    do begin
      @(posedge i_clk);
      lat++;
    end while (i_rsp.done !== 1'b1 && lat < 200);
    rsp = i_rsp;
  endtask
endmodule
`default_nettype wire

// ===== bench/ffau_top_assertions.sv
// port-level checks of the float/fixed arithmetic unit
`timescale 1ns/1ns
`default_nettype none
module ffau_top_assertions
  import ffau_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire ffau_pkg::ffau_req_t i_req,
  input wire logic o_ready,
  input wire ffau_pkg::ffau_rsp_t o_rsp
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic taken;
  logic [6:0] low_cnt;
  assign taken = i_req.valid && o_ready && !i_srst;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      low_cnt <= 7'h0;
    end else begin
      low_cnt <= o_ready ? 7'h0 : low_cnt + 7'h1;
    end
  end

  function automatic logic is_ind(input logic [59:0] x);
    return x[59:48] == EXP_POS_IND || x[59:48] == EXP_NEG_IND;
  endfunction

  function automatic logic [59:0] oc60(input logic [59:0] x, input logic [59:0] y);
    logic [60:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[59:0] + 60'(s[60]);
  endfunction

  function automatic logic [17:0] oc18(input logic [17:0] x, input logic [17:0] y);
    logic [18:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[17:0] + 18'(s[18]);
  endfunction

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_answer;
    o_rsp.done && o_ready;
  endsequence

  sequence s_div_wait;
    !o_ready && !o_rsp.done;
  endsequence

  norm_flag_a: assert property (
    o_rsp.done |-> o_rsp.norm == (o_rsp.result[59] ^ o_rsp.result[47]))
    else $error("normalized flag disagrees with result word");
  fast_answer_a: assert property (
    taken && i_req.op != OP_FDIV |=> s_answer)
    else $error("one-cycle operation not answered next cycle");
  div_busy_a: assert property (
    taken && i_req.op == OP_FDIV |=> s_answer or s_div_wait [*8])
    else $error("divide neither answered nor busy");
  div_length_a: assert property (
    $rose(o_ready) |-> low_cnt == 7'h61 && o_rsp.done)
    else $error("divide busy period has wrong length");
  hold_result_a: assert property (
    !o_rsp.done && !$past(i_srst) |-> $stable(o_rsp.result))
    else $error("result changed without done");
  ind_result_a: assert property (
    taken && i_req.op inside {OP_FADD, OP_FSUB, OP_FMUL, OP_FDIV}
    && (is_ind(i_req.a) || is_ind(i_req.b)) |=> o_rsp.done && o_rsp.result == WORD_IND)
    else $error("indefinite operand did not give indefinite");
  long_add_a: assert property (
    taken && i_req.op == OP_LADD |=> o_rsp.result == oc60($past(i_req.a), $past(i_req.b)))
    else $error("long add sum wrong");
  incr_sub_a: assert property (
    taken && i_req.op == OP_ISUB
    |=> o_rsp.result == {42'h0, oc18($past(i_req.a[17:0]), ~$past(i_req.b[17:0]))})
    else $error("increment subtract wrong");
  norm_result_a: assert property (
    taken && i_req.op == OP_NORM && i_req.b[58] != i_req.b[59]
    && i_req.b[59:48] != EXP_POS_INF && i_req.b[59:48] != EXP_NEG_INF
    && i_req.b[47:0] != {48{i_req.b[59]}}
    |=> o_rsp.norm && o_rsp.result[59] == $past(i_req.b[59]))
    else $error("normalize left result unnormalized");
endmodule
`default_nettype wire

// ===== bench/tb_float_fixed_arith_unit.sv
// self-checking bench of the float/fixed arithmetic unit
`timescale 1ns/1ns
`default_nettype none
module tb_float_fixed_arith_unit;
  import ffau_pkg::*;
  localparam logic [47:0] C8 = 48'h8000_0000_0000;
  localparam logic [47:0] CC = 48'hC000_0000_0000;
  logic i_clk;
  logic i_srst;
  ffau_req_t i_req;
  logic o_ready;
  ffau_rsp_t o_rsp;
  int mismatches;
  int n_compared;
  int cycles;

  ffau_top dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req), .o_ready(o_ready),
    .o_rsp(o_rsp));
  ffau_issuer iss_u (.i_clk(i_clk), .i_ready(o_ready), .i_rsp(o_rsp), .o_req(i_req));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [59:0] pk(input logic s, input int e, input logic [47:0] m);
    logic [59:0] w;
    w = {1'b0, 11'(e + ((e < 0) ? 32'h3FF : 32'h400)), m};
    return s ? ~w : w;
  endfunction

  task automatic chk(input string what, input logic [59:0] exp, input logic [59:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(input ffau_op_t op, input logic dbl, input logic rnd,
                     input logic [59:0] a, input logic [59:0] b,
                     input logic [59:0] exp, input int exp_lat, output ffau_rsp_t r);
    int lat;
    iss_u.issue(op, dbl, rnd, a, b, r, lat);
    chk("result", exp, r.result);
    chk("latency", 60'(exp_lat), 60'(lat));
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_normalize();
    ffau_rsp_t r;
    run(OP_NORM, 1'b0, 1'b0, '0, pk(1'b0, 0, 48'h1), pk(1'b0, -47, C8), 1, r);
    chk("shift", 60'h2F, 60'(r.shift));
    chk("norm", 60'h1, 60'(r.norm));
    run(OP_NORM, 1'b0, 1'b0, '0, pk(1'b1, 3, 48'h1), pk(1'b1, -44, C8), 1, r);
    $display("test normalize finished");
  endtask

  task automatic t_add();
    ffau_rsp_t r;
    logic [59:0] a;
    logic [59:0] b;
    a = pk(1'b0, 1, C8);
    b = pk(1'b0, 0, 48'h8000_0000_0001);
    run(OP_FADD, 1'b0, 1'b0, a, b, pk(1'b0, 1, CC), 1, r);
    run(OP_FADD, 1'b1, 1'b0, a, b, pk(1'b0, -47, C8), 1, r);
    a = pk(1'b0, 0, C8);
    b = pk(1'b0, 0, 48'h4000_0000_0000);
    run(OP_FSUB, 1'b0, 1'b0, a, b, b, 1, r);
    chk("sub norm", 60'h0, 60'(r.norm));
    $display("test add finished");
  endtask

  task automatic t_mul();
    ffau_rsp_t r;
    logic [59:0] a;
    logic [59:0] b;
    a = pk(1'b0, 0, C8);
    run(OP_FMUL, 1'b0, 1'b0, a, a, pk(1'b0, 47, C8), 1, r);
    chk("mul norm", 60'h1, 60'(r.norm));
    run(OP_FMUL, 1'b1, 1'b0, a, a, WORD_ZERO, 1, r);
    a = pk(1'b0, 1, 48'h8000_0000_0001);
    b = pk(1'b0, 1, 48'h2);
    run(OP_FMUL, 1'b0, 1'b0, a, b, pk(1'b0, 50, 48'h1), 1, r);
    run(OP_FMUL, 1'b1, 1'b0, a, b, pk(1'b0, 2, 48'h2), 1, r);
    a = pk(1'b0, 0, 48'h3);
    b = pk(1'b1, 0, 48'h5);
    run(OP_FMUL, 1'b1, 1'b0, a, b, ~60'h00F, 1, r);
    $display("test multiply finished");
  endtask

  task automatic t_div();
    ffau_rsp_t r;
    logic [59:0] b;
    b = pk(1'b0, -46, C8);
    run(OP_FDIV, 1'b0, 1'b0, pk(1'b0, 0, 48'h7), b, pk(1'b0, -2, 48'hE), 98, r);
    b = pk(1'b0, 0, C8);
    run(OP_FDIV, 1'b0, 1'b0, pk(1'b0, 0, CC), b, pk(1'b0, -47, CC), 98, r);
    chk("div norm", 60'h1, 60'(r.norm));
    $display("test divide finished");
  endtask

  task automatic t_special();
    ffau_rsp_t r;
    logic [59:0] w;
    w = pk(1'b0, 0, C8);
    run(OP_FADD, 1'b0, 1'b0, WORD_IND, w, WORD_IND, 1, r);
    run(OP_FMUL, 1'b0, 1'b0, w, {EXP_NEG_IND, 48'h0}, WORD_IND, 1, r);
    run(OP_FDIV, 1'b0, 1'b0, w, WORD_IND, WORD_IND, 1, r);
    run(OP_FADD, 1'b0, 1'b0, WORD_INF_POS, ~WORD_INF_POS, WORD_IND, 1, r);
    run(OP_FSUB, 1'b0, 1'b0, w, WORD_INF_POS, ~WORD_INF_POS, 1, r);
    run(OP_FMUL, 1'b0, 1'b0, WORD_INF_POS, WORD_ZERO, WORD_IND, 1, r);
    run(OP_FMUL, 1'b0, 1'b0, w, ~WORD_ZERO, WORD_ZERO, 1, r);
    run(OP_FDIV, 1'b0, 1'b0, w, WORD_ZERO, WORD_INF_POS, 1, r);
    run(OP_FDIV, 1'b0, 1'b0, WORD_ZERO, w, WORD_ZERO, 1, r);
    $display("test special operands finished");
  endtask

  task automatic t_fixed();
    ffau_rsp_t r;
    run(OP_LADD, 1'b0, 1'b0, 60'h7FF_FFFF_FFFF_FFFF, 60'h1, {1'b1, 59'h0}, 1, r);
    run(OP_LADD, 1'b0, 1'b0, 60'h5, ~60'h7, ~60'h2, 1, r);
    run(OP_LSUB, 1'b0, 1'b0, 60'h5, 60'h7, ~60'h2, 1, r);
    run(OP_IADD, 1'b0, 1'b0, 60'hABC_0000_0001_FFFF, 60'h1, 60'h2_0000, 1, r);
    run(OP_IADD, 1'b0, 1'b0, 60'h5, 60'h3_FFFC, 60'h2, 1, r);
    run(OP_ISUB, 1'b0, 1'b0, 60'h3, 60'h5, 60'h3_FFFD, 1, r);
    $display("test fixed point finished");
  endtask

  task automatic t_round();
    ffau_rsp_t r;
    logic [59:0] a;
    a = pk(1'b0, 0, 48'h8000_0000_0001);
    run(OP_FADD, 1'b1, 1'b1, pk(1'b0, 1, C8), a, pk(1'b0, 1, 48'hC000_0000_0001), 1, r);
    run(OP_FMUL, 1'b0, 1'b1, pk(1'b0, 0, 48'hFFFF_FFFF_FFFF), pk(1'b0, 0, 48'h1_0000),
        pk(1'b0, 48, 48'h1_0000), 1, r);
    run(OP_FDIV, 1'b0, 1'b1, pk(1'b0, 0, C8), pk(1'b0, 0, CC),
        pk(1'b0, -48, 48'hAAAA_AAAA_AAAB), 98, r);
    chk("round div norm", 60'h1, 60'(r.norm));
    $display("test rounding finished");
  endtask

  // ------------------------------------------------------------
  // clock, timeout, main sequence
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial begin
    cycles = 0;
  end

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      report_and_stop();
    end
  end

  initial begin
    i_srst = 1'b1;
    mismatches = 0;
    n_compared = 0;
    repeat (5) @(posedge i_clk);
    chk("ready in reset", 60'h1, 60'(o_ready));
    i_srst <= 1'b0;
    t_normalize();
    t_add();
    t_mul();
    t_div();
    t_special();
    t_fixed();
    t_round();
    report_and_stop();
  end
endmodule

bind ffau_top ffau_top_assertions chk_u (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req),
  .o_ready(o_ready), .o_rsp(o_rsp));
`default_nettype wire

// ===== verilog/ffau_divider.sv
// iterative restoring divider, one quotient bit per clock
`timescale 1ns/1ns
`default_nettype none
module ffau_divider #(
  parameter int NW = 96,
  parameter int DW = 48
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_start,
  input wire logic [NW-1:0] i_num,
  input wire logic [DW-1:0] i_den,
  output var logic o_done,
  output var logic [NW-1:0] o_quot
);
  import ffau_pkg::*;

  localparam int CW = $clog2(NW + 1);

  if (NW < 2 || DW < 2 || NW < DW) begin : g_chk
    $error("ffau_divider: widths out of range");
  end

  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [DW-1:0] rem;
    logic [NW-1:0] quo;
    logic [DW-1:0] den;
  } ffau_div_state_t;

  ffau_div_state_t st;
  ffau_div_state_t next_st;
  logic [DW:0] trial;
  logic fit;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    trial = {st.rem, st.quo[NW-1]};
    fit = trial >= {1'b0, st.den};
    if (i_srst) begin
      next_st = '0;
    end else if (st.busy) begin
      next_st.quo = {st.quo[NW-2:0], fit};
      next_st.rem = fit ? DW'(trial - {1'b0, st.den}) : trial[DW-1:0];
      next_st.cnt = CW'(st.cnt - 1'b1);
      if (st.cnt == CW'(1)) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end else if (i_start) begin
      next_st.busy = 1'b1;
      next_st.cnt = CW'(NW);
      next_st.rem = '0;
      next_st.quo = i_num;
      next_st.den = i_den;
    end
  end

  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  assign o_done = st.done;
  assign o_quot = st.quo;

endmodule
`default_nettype wire

// ===== verilog/ffau_pkg.sv
// shared types and constants of the float/fixed arithmetic unit
package ffau_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int WORD_W = 60;
  localparam int COEF_W = 48;
  localparam int ACC_W = 96;
  localparam int EXP_W = 14;
  localparam int SHIFT_W = 6;
  localparam int FIX_W = 18;

  // ------------------------------------------------------------
  // packed exponent fields of special operands (sign + 11 bits)
  // ------------------------------------------------------------
  localparam logic [11:0] EXP_POS_INF = 12'h7FF;
  localparam logic [11:0] EXP_NEG_INF = 12'h800;
  localparam logic [11:0] EXP_POS_IND = 12'h3FF;
  localparam logic [11:0] EXP_NEG_IND = 12'hC00;
  localparam logic [11:0] EXP_POS_UND = 12'h000;
  localparam logic [11:0] EXP_NEG_UND = 12'hFFF;

  // ------------------------------------------------------------
  // exponent arithmetic
  // ------------------------------------------------------------
  localparam logic signed [EXP_W-1:0] EXP_BIAS_POS = 14'sh400;
  localparam logic signed [EXP_W-1:0] EXP_BIAS_NEG = 14'sh3FF;
  localparam logic signed [EXP_W-1:0] EXP_MAX = 14'sh3FF;
  localparam logic signed [EXP_W-1:0] EXP_MIN = -EXP_MAX;
  localparam logic signed [EXP_W-1:0] EXP_OCT60 = 14'sh30;
  localparam logic signed [EXP_W-1:0] EXP_ONE = 14'sh1;

  // ------------------------------------------------------------
  // fixed result words
  // ------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_IND = 60'h3FF_0000_0000_0000;
  localparam logic [WORD_W-1:0] WORD_INF_POS = 60'h7FF_0000_0000_0000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 60'h000_0000_0000_0000;
  localparam logic [ACC_W-1:0] ACC_RND = 96'h0000_0000_0000_8000_0000_0000;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_FADD, OP_FSUB, OP_FMUL, OP_FDIV, OP_NORM, OP_LADD, OP_LSUB, OP_IADD, OP_ISUB
  } ffau_op_t;

  typedef enum logic {FFAU_S_IDLE, FFAU_S_DIV} ffau_fsm_t;

  typedef struct packed {
    logic valid;
    ffau_op_t op;
    logic dbl;
    logic rnd;
    logic [WORD_W-1:0] a;
    logic [WORD_W-1:0] b;
  } ffau_req_t;

  typedef struct packed {
    logic done;
    logic [WORD_W-1:0] result;
    logic [SHIFT_W-1:0] shift;
    logic norm;
  } ffau_rsp_t;

  typedef struct packed {
    logic sign;
    logic signed [EXP_W-1:0] exp;
    logic [COEF_W-1:0] mag;
    logic inf;
    logic indefinite_value;
    logic und;
    logic zexp;
    logic norm;
  } ffau_opnd_t;

  typedef struct packed {
    ffau_fsm_t fsm;
    logic rdy;
    ffau_rsp_t rsp;
    logic qsg;
    logic signed [EXP_W-1:0] qexp;
  } ffau_state_t;

  localparam ffau_state_t ST_RST = '{
    fsm: FFAU_S_IDLE, rdy: 1'b1, rsp: '0, qsg: 1'b0, qexp: '0
  };

endpackage

// ===== verilog/ffau_top.sv
// float and fixed arithmetic unit for 60-bit words
// ------------------------------------------------------------
// Function
// - word is normalized when coefficient sign differs from bit 47
// - normalize shifts coefficient up to bit 47, exponent drops by shift
// - single multiply and divide give normalized results from normalized operands
// - add and subtract results are never normalized implicitly
// - rounding adjusts operands first, same cycle count as unrounded
// - smaller-exponent coefficient goes upper half, shifted right by difference
// - single add returns upper 48 sum bits with larger exponent, one higher on carry out
// - double add returns lower 48 sum bits, larger exponent minus 48
// - single multiply returns upper 48 product bits, exponent sum plus 48, or one bit lower and plus 47 to normalize
// - double multiply returns lower 48 product bits, plain exponent sum
// - long add/subtract on 60-bit one's complement, overflow dropped
// - increment add/subtract on 18-bit one's complement, overflow dropped
// - double multiply with +0 exponents gives sign-extended 48-bit integer
// - that integer multiply with both coefficients normalized gives underflow
// - quotient exponent is dividend minus divisor exponent minus 48
// - operand classes select infinity, zero or indefinite outcomes
// - any indefinite operand to add, subtract, multiply or divide yields positive indefinite
// - specials known by packed exponent: infinity, indefinite, underflow
// - 48-bit coefficient low, sign on top, one's complement, biased exponent
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module ffau_top (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire ffau_pkg::ffau_req_t i_req,
  output var logic o_ready,
  output var ffau_pkg::ffau_rsp_t o_rsp
);
  import ffau_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [WORD_W-1:0] pack(
    input logic sg,
    input logic signed [EXP_W-1:0] e,
    input logic [COEF_W-1:0] m
  );
    logic signed [EXP_W-1:0] f;
    logic [WORD_W-1:0] w;
    f = (e >= 0) ? e + EXP_BIAS_POS : e + EXP_BIAS_NEG;
    w = {1'b0, f[WORD_W-COEF_W-2:0], m};
    if (e > EXP_MAX) begin
      w = WORD_INF_POS;
    end
    if (e < EXP_MIN) begin
      return WORD_ZERO;
    end
    return sg ? ~w : w;
  endfunction

  function automatic logic [WORD_W-1:0] inf_w(input logic sg);
    return sg ? ~WORD_INF_POS : WORD_INF_POS;
  endfunction

  function automatic logic [WORD_W-1:0] oc_add60(
    input logic [WORD_W-1:0] x,
    input logic [WORD_W-1:0] y
  );
    logic [WORD_W:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[WORD_W-1:0] + {{(WORD_W-1){1'b0}}, s[WORD_W]};
  endfunction

  function automatic logic [FIX_W-1:0] oc_add18(
    input logic [FIX_W-1:0] x,
    input logic [FIX_W-1:0] y
  );
    logic [FIX_W:0] s;
    s = {1'b0, x} + {1'b0, y};
    return s[FIX_W-1:0] + {{(FIX_W-1){1'b0}}, s[FIX_W]};
  endfunction

  function automatic logic [SHIFT_W-1:0] lead0(input logic [COEF_W-1:0] m);
    logic [SHIFT_W-1:0] n;
    n = SHIFT_W'(COEF_W);
    for (int i = 0; i < COEF_W; i++) begin
      if (m[i]) begin
        n = SHIFT_W'(COEF_W - 1 - i);
      end
    end
    return n;
  endfunction

  // ------------------------------------------------------------
  // operand decode
  // ------------------------------------------------------------
  ffau_opnd_t ua;
  ffau_opnd_t ub;

  ffau_unpack u_unpack_a (
    .i_word(i_req.a),
    .o_opnd(ua)
  );

  ffau_unpack u_unpack_b (
    .i_word(i_req.b),
    .o_opnd(ub)
  );

  ffau_state_t st;
  ffau_state_t next_st;
  logic sel_dbl;

  // rounded forms only ever deliver the upper half
  assign sel_dbl = i_req.dbl & ~i_req.rnd;

  // ------------------------------------------------------------
  // add / subtract datapath
  // ------------------------------------------------------------
  logic bs;
  logic a_big;
  logic signed [EXP_W-1:0] el;
  logic [EXP_W-1:0] diff;
  logic [COEF_W-1:0] ml;
  logic [COEF_W-1:0] ms;
  logic sl;
  logic ss;
  logic [ACC_W-1:0] rnd_bit;
  logic [ACC_W-1:0] xl;
  logic [ACC_W-1:0] xs;
  logic [ACC_W:0] asum;
  logic [ACC_W-1:0] acc;
  logic cy;
  logic asg;
  logic [COEF_W-1:0] a_coef;
  logic signed [EXP_W-1:0] a_exp;

  assign bs = ub.sign ^ (i_req.op == OP_FSUB);
  assign a_big = ua.exp >= ub.exp;
  assign el = a_big ? ua.exp : ub.exp;
  assign diff = a_big ? EXP_W'(ua.exp - ub.exp) : EXP_W'(ub.exp - ua.exp);
  assign ml = a_big ? ua.mag : ub.mag;
  assign ms = a_big ? ub.mag : ua.mag;
  assign sl = a_big ? ua.sign : bs;
  assign ss = a_big ? bs : ua.sign;
  assign rnd_bit = i_req.rnd ? ACC_RND : '0;
  assign xl = {ml, {COEF_W{1'b0}}} | rnd_bit;
  assign xs = ({ms, {COEF_W{1'b0}}} | rnd_bit) >> diff;
  assign asum = (sl == ss) ? {1'b0, xl} + {1'b0, xs} :
                (xl >= xs) ? {1'b0, xl - xs} : {1'b0, xs - xl};
  assign acc = asum[ACC_W-1:0];
  assign cy = asum[ACC_W];
  assign asg = ((sl == ss) || (xl >= xs)) ? sl : ss;
  assign a_coef = sel_dbl ? acc[COEF_W-1:0] :
                  cy ? {1'b1, acc[ACC_W-1:COEF_W+1]} : acc[ACC_W-1:COEF_W];
  assign a_exp = sel_dbl ? el - EXP_OCT60 : (cy ? el + EXP_ONE : el);

  // ------------------------------------------------------------
  // multiply datapath
  // ------------------------------------------------------------
  logic [ACC_W:0] pr;
  logic [ACC_W-1:0] prod;
  logic signed [EXP_W-1:0] msum;
  logic msg;
  logic bnorm;
  logic imul;
  logic [COEF_W-1:0] m_coef;
  logic signed [EXP_W-1:0] m_exp;
  logic [WORD_W-1:0] ival;

  // half-weight round term folded into the multiplier operand
  assign pr = ua.mag * {ub.mag, i_req.rnd};
  assign prod = pr[ACC_W:1];
  assign msum = ua.exp + ub.exp;
  assign msg = ua.sign ^ ub.sign;
  assign bnorm = ua.norm & ub.norm;
  assign imul = sel_dbl && ua.zexp && ub.zexp;
  assign m_coef = sel_dbl ? prod[COEF_W-1:0] :
                  (bnorm && !prod[ACC_W-1]) ? prod[ACC_W-2:COEF_W-1] :
                  prod[ACC_W-1:COEF_W];
  assign m_exp = sel_dbl ? msum :
                 (bnorm && !prod[ACC_W-1]) ? msum + EXP_OCT60 - EXP_ONE :
                 msum + EXP_OCT60;
  assign ival = msg ? ~{{(WORD_W-COEF_W){1'b0}}, prod[COEF_W-1:0]} :
                {{(WORD_W-COEF_W){1'b0}}, prod[COEF_W-1:0]};

  // ------------------------------------------------------------
  // divide datapath
  // ------------------------------------------------------------
  logic div_go;
  logic [ACC_W-1:0] dnum;
  logic [ACC_W-1:0] dq;
  logic dq_done;
  logic a_zero;
  logic b_zero;

  assign a_zero = ua.und;
  assign b_zero = ub.und || (ub.mag == '0);
  // rounded divide adds half the divisor to the dividend
  assign dnum = {ua.mag, {COEF_W{1'b0}}} +
                (i_req.rnd ? {{(COEF_W+1){1'b0}}, ub.mag[COEF_W-1:1]} : '0);

  ffau_divider #(
    .NW(ACC_W),
    .DW(COEF_W)
  ) u_divider (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_start(div_go),
    .i_num(dnum),
    .i_den(ub.mag),
    .o_done(dq_done),
    .o_quot(dq)
  );

  // ------------------------------------------------------------
  // normalize datapath
  // ------------------------------------------------------------
  logic [SHIFT_W-1:0] lz;
  logic signed [EXP_W-1:0] n_exp;

  assign lz = lead0(ub.mag);
  assign n_exp = ub.exp - $signed({{(EXP_W-SHIFT_W){1'b0}}, lz});

  // ------------------------------------------------------------
  // control
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rsp.done = 1'b0;
    div_go = 1'b0;
    if (i_srst) begin
      next_st = ST_RST;
    end else begin
      case (st.fsm)
        FFAU_S_IDLE: begin
          if (i_req.valid) begin
            next_st.rsp.done = 1'b1;
            next_st.rsp.shift = '0;
            case (i_req.op)
              OP_FADD, OP_FSUB: begin
                if (ua.indefinite_value || ub.indefinite_value) begin
                  next_st.rsp.result = WORD_IND;
                end else if (ua.inf && ub.inf) begin
                  next_st.rsp.result = (ua.sign == bs) ? inf_w(ua.sign) : WORD_IND;
                end else if (ua.inf) begin
                  next_st.rsp.result = inf_w(ua.sign);
                end else if (ub.inf) begin
                  next_st.rsp.result = inf_w(bs);
                end else begin
                  next_st.rsp.result = pack(asg, a_exp, a_coef);
                end
              end
              OP_FMUL: begin
                if (ua.indefinite_value || ub.indefinite_value) begin
                  next_st.rsp.result = WORD_IND;
                end else if ((ua.inf && ub.und) || (ua.und && ub.inf)) begin
                  next_st.rsp.result = WORD_IND;
                end else if (ua.inf || ub.inf) begin
                  next_st.rsp.result = inf_w(msg);
                end else if (ua.und || ub.und) begin
                  next_st.rsp.result = WORD_ZERO;
                end else if (imul) begin
                  next_st.rsp.result = bnorm ? WORD_ZERO : ival;
                end else begin
                  next_st.rsp.result = pack(msg, m_exp, m_coef);
                end
              end
              OP_FDIV: begin
                if (ua.indefinite_value || ub.indefinite_value) begin
                  next_st.rsp.result = WORD_IND;
                end else if ((ua.inf && ub.inf) || (a_zero && b_zero)) begin
                  next_st.rsp.result = WORD_IND;
                end else if (ua.inf || b_zero) begin
                  next_st.rsp.result = inf_w(msg);
                end else if (ub.inf || a_zero) begin
                  next_st.rsp.result = WORD_ZERO;
                end else begin
                  next_st.rsp.done = 1'b0;
                  next_st.rdy = 1'b0;
                  next_st.fsm = FFAU_S_DIV;
                  next_st.qsg = msg;
                  next_st.qexp = ua.exp - ub.exp - EXP_OCT60;
                  div_go = 1'b1;
                end
              end
              OP_NORM: begin
                next_st.rsp.shift = lz;
                if (ub.inf || ub.indefinite_value) begin
                  next_st.rsp.result = i_req.b;
                end else if (ub.mag == '0) begin
                  next_st.rsp.result = WORD_ZERO;
                end else begin
                  next_st.rsp.result = pack(ub.sign, n_exp, ub.mag << lz);
                end
              end
              OP_LADD: next_st.rsp.result = oc_add60(i_req.a, i_req.b);
              OP_LSUB: next_st.rsp.result = oc_add60(i_req.a, ~i_req.b);
              OP_IADD: begin
                next_st.rsp.result = {{(WORD_W-FIX_W){1'b0}},
                                      oc_add18(i_req.a[FIX_W-1:0], i_req.b[FIX_W-1:0])};
              end
              OP_ISUB: begin
                next_st.rsp.result = {{(WORD_W-FIX_W){1'b0}},
                                      oc_add18(i_req.a[FIX_W-1:0], ~i_req.b[FIX_W-1:0])};
              end
              default: next_st.rsp.result = WORD_ZERO;
            endcase
          end
        end
        FFAU_S_DIV: begin
          if (dq_done) begin
            // a dividend below twice the divisor keeps the quotient within 49 bits
            if (dq[COEF_W]) begin
              next_st.rsp.result = pack(st.qsg, st.qexp + EXP_ONE, dq[COEF_W:1]);
            end else begin
              next_st.rsp.result = pack(st.qsg, st.qexp, dq[COEF_W-1:0]);
            end
            next_st.rsp.shift = '0;
            next_st.rsp.done = 1'b1;
            next_st.rdy = 1'b1;
            next_st.fsm = FFAU_S_IDLE;
          end
        end
        default: next_st = ST_RST;
      endcase
    end
    next_st.rsp.norm = next_st.rsp.result[WORD_W-1] ^ next_st.rsp.result[COEF_W-1];
  end

  always_ff @(posedge i_clk) begin
    st <= next_st;
  end

  assign o_ready = st.rdy;
  assign o_rsp = st.rsp;

endmodule
`default_nettype wire

// ===== verilog/ffau_unpack.sv
// operand unpacking and special-value classification
`timescale 1ns/1ns
`default_nettype none
module ffau_unpack (
  input wire logic [ffau_pkg::WORD_W-1:0] i_word,
  output var ffau_pkg::ffau_opnd_t o_opnd
);
  import ffau_pkg::*;

  logic [WORD_W-1:0] t;
  logic [11:0] raw;
  logic signed [EXP_W-1:0] e;

  always_comb begin
    raw = i_word[WORD_W-1:COEF_W];
    t = i_word[WORD_W-1] ? ~i_word : i_word;
    e = $signed({3'h0, t[WORD_W-2:COEF_W]}) - (t[WORD_W-2] ? EXP_BIAS_POS : EXP_BIAS_NEG);
    o_opnd.sign = i_word[WORD_W-1];
    o_opnd.exp = e;
    o_opnd.mag = t[COEF_W-1:0];
    o_opnd.inf = (raw == EXP_POS_INF) || (raw == EXP_NEG_INF);
    o_opnd.indefinite_value = (raw == EXP_POS_IND) || (raw == EXP_NEG_IND);
    o_opnd.und = (raw == EXP_POS_UND) || (raw == EXP_NEG_UND);
    o_opnd.zexp = (e == '0) && !o_opnd.indefinite_value;
    o_opnd.norm = i_word[WORD_W-1] ^ i_word[COEF_W-1];
  end

endmodule
`default_nettype wire
